// >>> core/sfc_pkg.sv
// Constants, types and timing counts for the sector flash host controller.
// Assumes a 25 MHz clock; all pin timing is counted in whole clock cycles.
package sfc_pkg;

  // ****************************************************************
  // Clock and pin timing
  // ****************************************************************
  localparam int SFC_CLK_PERIOD_NS = 40;
  localparam int SFC_T_WP_NS       = 200;  // Write pulse width, least.
  localparam int SFC_T_WPH_NS      = 200;  // Write pulse high, least.
  localparam int SFC_T_ACC_NS      = 200;  // Address to output, most.
  localparam int SFC_T_OEHP_NS     = 150;  // Output enable high pulse, least.
  localparam int SFC_T_BLC_US      = 150;  // Byte load cycle, most.
  localparam int SFC_T_WC_MS       = 20;   // Program cycle, most.
  localparam int SFC_WP_CYC   = (SFC_T_WP_NS + SFC_CLK_PERIOD_NS - 1) / SFC_CLK_PERIOD_NS;
  localparam int SFC_WPH_CYC  = (SFC_T_WPH_NS + SFC_CLK_PERIOD_NS - 1) / SFC_CLK_PERIOD_NS;
  localparam int SFC_RD_CYC   = (SFC_T_ACC_NS + SFC_CLK_PERIOD_NS - 1) / SFC_CLK_PERIOD_NS;
  localparam int SFC_OEHP_CYC = (SFC_T_OEHP_NS + SFC_CLK_PERIOD_NS - 1) / SFC_CLK_PERIOD_NS;
  localparam int SFC_BLC_CYC  = SFC_T_BLC_US * 1000 / SFC_CLK_PERIOD_NS;
  localparam int SFC_WC_CYC   = SFC_T_WC_MS * 1000000 / SFC_CLK_PERIOD_NS;

  // ****************************************************************
  // Page geometry and command words
  // ****************************************************************
  localparam int          SFC_PAGE_BYTES = 256;
  localparam int          SFC_FIFO_DEPTH = 8;
  localparam logic [14:0] SFC_CMD_ADDR_A = 15'h5555;
  localparam logic [14:0] SFC_CMD_ADDR_B = 15'h2aaa;
  localparam logic [7:0]  SFC_CODE_UNLK1 = 8'haa;
  localparam logic [7:0]  SFC_CODE_UNLK2 = 8'h55;
  localparam logic [7:0]  SFC_CODE_PROG  = 8'ha0;
  localparam logic [7:0]  SFC_CODE_IDIN  = 8'h90;
  localparam logic [7:0]  SFC_CODE_IDOUT = 8'hf0;
  localparam logic [7:0]  SFC_CODE_LOCK  = 8'h80;
  localparam logic [7:0]  SFC_CODE_ARM   = 8'h40;
  localparam logic [7:0]  SFC_LOCK_DATA  = 8'hff;
  localparam logic [18:0] SFC_LOCK_LO    = 19'h00000;
  localparam logic [18:0] SFC_LOCK_HI    = 19'h7ffff;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {SFC_OP_READ, SFC_OP_PROG, SFC_OP_ID, SFC_OP_LOCK} sfc_op_type;

  typedef struct packed {
    sfc_op_type  op;
    logic [18:0] addr;
  } sfc_req_type;

  typedef struct packed {
    logic        done;
    logic        err;
    logic [15:0] rdata;
  } sfc_rsp_type;

  typedef struct packed {
    logic [18:0] addr;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [7:0]  dq_out;
    logic        dq_oe;
  } sfc_pins_type;

endpackage

// >>> core/sfc_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides.
// Assumes DEPTH is a power of two; one clock, synchronous active-low reset.
`timescale 1ns/100ps
module sfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      wr_d;
  logic [AW:0]      rd_q;
  logic [AW:0]      rd_d;
  logic             push;
  logic             pop;

  // Pointers carry one extra bit so full and empty differ honestly.
  always_comb begin
    in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
    out_valid = (wr_q != rd_q);
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wr_d      = push ? wr_q + 1'b1 : wr_q;
    rd_d      = pop ? rd_q + 1'b1 : rd_q;
    out_data  = mem_q[rd_q[AW-1:0]];
  end

  // Pointer registers.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // Storage entries; each one loads only when the write pointer names it.
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    logic [WIDTH-1:0] ent_d;
    always_comb begin
      ent_d = (push && (wr_q[AW-1:0] == AW'(i))) ? in_data : mem_q[i];
    end
    always_ff @(posedge clk) begin
      mem_q[i] <= ent_d;
    end
  end

endmodule

// >>> core/sfc_host.sv
// Host controller that drives a parallel sector flash through its pins.
// Assumes pin inputs are synchronous to clk and the flash sees the pins directly.
//
// Summary of operation
// - During a page load every write strobe presents the sector number on A8 to A18.
// - All 256 bytes of a page are loaded before the controller lets the program start, unless the byte stream stalls past the 150 us load limit.
// - Successive byte writes in a load start no more than 3751 clock cycles (150.04 us) apart.
// - All polling reads of one program use the same address.
`timescale 1ns/100ps
module sfc_host #(
  parameter int unsigned WC_CYCLES = sfc_pkg::SFC_WC_CYC
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // Request port
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire sfc_pkg::sfc_req_type req,
  // Page data stream
  input  wire logic                 wr_valid,
  output logic                      wr_ready,
  input  wire logic [7:0]           wr_data,
  // Response
  output sfc_pkg::sfc_rsp_type      rsp,
  // Flash pins
  output sfc_pkg::sfc_pins_type     pins,
  input  wire logic [7:0]           dq_in
);

  typedef enum logic [2:0] {ST_IDLE, ST_WSET, ST_WLOW, ST_WHIGH, ST_WAIT, ST_RLOW, ST_RHIGH}
    sfc_state_type;
  typedef enum logic [2:0] {PH_CMD, PH_LOAD, PH_LOCK, PH_POLL, PH_ID, PH_EXIT, PH_READ}
    sfc_phase_type;

  // ****************************************************************
  // State
  // ****************************************************************
  sfc_state_type         state_q, state_d;
  sfc_phase_type         phase_q, phase_d;
  sfc_pkg::sfc_op_type   op_q, op_d;
  sfc_pkg::sfc_pins_type pins_q, pins_d;
  sfc_pkg::sfc_rsp_type  rsp_q, rsp_d;
  logic [2:0]            cnt_q, cnt_d;
  logic [2:0]            idx_q, idx_d;
  logic [8:0]            byte_q, byte_d;
  logic [18:0]           addr_q, addr_d;
  logic [18:0]           last_q, last_d;
  logic                  bit7_q, bit7_d;
  logic                  prev6_q, prev6_d;
  logic                  havep_q, havep_d;
  logic [7:0]            rbyte_q, rbyte_d;
  logic [11:0]           blc_q, blc_d;
  logic [19:0]           wc_q, wc_d;
  logic                  wr_go, rd_go, fin;
  logic [18:0]           go_addr;
  logic [7:0]            go_data;
  logic [7:0]            code;
  logic [22:0]           cword;
  logic                  fifo_valid, fifo_pop;
  logic [7:0]            fifo_data;

  // Eight bytes of slack let the source run ahead of the pin timing.
  sfc_fifo #(.WIDTH(8), .DEPTH(sfc_pkg::SFC_FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // unlock words
  // Unlock words repeat every three writes; the third carries the command code.
  function automatic logic [22:0] cmd_word(input logic [2:0] i, input logic [7:0] c);
    case (i)
      3'd0, 3'd3: cmd_word = {sfc_pkg::SFC_CMD_ADDR_A, sfc_pkg::SFC_CODE_UNLK1};
      3'd1, 3'd4: cmd_word = {sfc_pkg::SFC_CMD_ADDR_B, sfc_pkg::SFC_CODE_UNLK2};
      3'd2:       cmd_word = {sfc_pkg::SFC_CMD_ADDR_A, c};
      default:    cmd_word = {sfc_pkg::SFC_CMD_ADDR_A, sfc_pkg::SFC_CODE_ARM};
    endcase
  endfunction

  assign req_ready = (state_q == ST_IDLE);
  assign pins      = pins_q;
  assign rsp       = rsp_q;

  // ****************************************************************
  // Sequencer next state
  // ****************************************************************
  // One process steers the pins; each bus cycle ends in a decision on the phase.
  always_comb begin
    state_d = state_q;  phase_d = phase_q;  op_d = op_q;  pins_d = pins_q;
    rsp_d = rsp_q;  rsp_d.done = 1'b0;  cnt_d = cnt_q + 3'd1;  idx_d = idx_q;
    byte_d = byte_q;  addr_d = addr_q;  last_d = last_q;  bit7_d = bit7_q;
    prev6_d = prev6_q;  havep_d = havep_q;  rbyte_d = rbyte_q;
    blc_d = (phase_q == PH_LOAD) ? blc_q + 12'd1 : 12'd0;
    wc_d = (phase_q == PH_POLL) ? wc_q + 20'd1 : 20'd0;
    wr_go = 1'b0;  rd_go = 1'b0;  fin = 1'b0;  fifo_pop = 1'b0;
    go_addr = addr_q;  go_data = 8'h00;
    if (phase_q == PH_EXIT) code = sfc_pkg::SFC_CODE_IDOUT;
    else if (op_q == sfc_pkg::SFC_OP_PROG) code = sfc_pkg::SFC_CODE_PROG;
    else if (op_q == sfc_pkg::SFC_OP_ID) code = sfc_pkg::SFC_CODE_IDIN;
    else code = sfc_pkg::SFC_CODE_LOCK;
    cword = cmd_word(idx_d + 3'd1, code);
    case (state_q)
      ST_IDLE: begin
        if (req_valid) begin
          op_d = req.op;  addr_d = req.addr;  rsp_d.err = 1'b0;  idx_d = 3'd0;
          if (req.op == sfc_pkg::SFC_OP_READ) begin
            phase_d = PH_READ;  rd_go = 1'b1;  go_addr = req.addr;
          end else begin
            phase_d = PH_CMD;  wr_go = 1'b1;
            // The first unlock word never depends on the command, so the stale op is harmless.
            cword = cmd_word(3'd0, code);
            go_addr = {4'h0, cword[22:8]};  go_data = cword[7:0];
          end
        end
      end
      ST_WSET: begin
        pins_d.we_n = 1'b0;  state_d = ST_WLOW;  cnt_d = 3'd0;
      end
      ST_WLOW: begin
        if (cnt_q == 3'(sfc_pkg::SFC_WP_CYC - 1)) begin
          pins_d.we_n = 1'b1;  state_d = ST_WHIGH;  cnt_d = 3'd0;
        end
      end
      ST_WHIGH: begin
        if (cnt_q == 3'(sfc_pkg::SFC_WPH_CYC - 1)) begin
          pins_d.dq_oe = 1'b0;
          if (phase_q == PH_CMD || phase_q == PH_EXIT) begin
            if (idx_q != ((op_q == sfc_pkg::SFC_OP_LOCK && phase_q == PH_CMD) ? 3'd5 : 3'd2))
            begin
              idx_d = idx_q + 3'd1;  wr_go = 1'b1;
              go_addr = {4'h0, cword[22:8]};  go_data = cword[7:0];
            end else if (phase_q == PH_EXIT) begin
              fin = 1'b1;  // back to normal reads
            end else if (op_q == sfc_pkg::SFC_OP_PROG) begin
              phase_d = PH_LOAD;  state_d = ST_WAIT;  byte_d = 9'd0;
            end else if (op_q == sfc_pkg::SFC_OP_ID) begin
              phase_d = PH_ID;  idx_d = 3'd0;  rd_go = 1'b1;  go_addr = 19'h00000;
            end else begin
              // lockout target chosen by the top address bit
              phase_d = PH_LOCK;  wr_go = 1'b1;  go_data = sfc_pkg::SFC_LOCK_DATA;
              go_addr = addr_q[18] ? sfc_pkg::SFC_LOCK_HI : sfc_pkg::SFC_LOCK_LO;
              last_d = go_addr;  bit7_d = go_data[7];
            end
          end else if (phase_q == PH_LOAD) begin
            state_d = ST_WAIT;
          end else begin
            phase_d = PH_POLL;  havep_d = 1'b0;  rd_go = 1'b1;  go_addr = last_q;
          end
        end
      end
      ST_WAIT: begin
        if (byte_q == 9'(sfc_pkg::SFC_PAGE_BYTES)) begin
          phase_d = PH_POLL;  havep_d = 1'b0;  rd_go = 1'b1;  go_addr = last_q;
        end else if (fifo_valid) begin
          fifo_pop = 1'b1;  wr_go = 1'b1;  blc_d = 12'd0;
          go_addr = {addr_q[18:8], byte_q[7:0]};  go_data = fifo_data;
          byte_d = byte_q + 9'd1;  last_d = go_addr;  bit7_d = fifo_data[7];
        end else if (blc_q == 12'(sfc_pkg::SFC_BLC_CYC)) begin
          // a starved load is reported, the flash programs what it got
          rsp_d.err = 1'b1;  phase_d = PH_POLL;  havep_d = 1'b0;
          rd_go = 1'b1;  go_addr = last_q;
        end
      end
      ST_RLOW: begin
        if (cnt_q == 3'(sfc_pkg::SFC_RD_CYC - 1)) begin
          rbyte_d = dq_in;  pins_d.oe_n = 1'b1;  state_d = ST_RHIGH;  cnt_d = 3'd0;
        end
      end
      ST_RHIGH: begin
        if (cnt_q == 3'(sfc_pkg::SFC_OEHP_CYC - 1)) begin
          case (phase_q)
            PH_READ: begin
              rsp_d.rdata = {8'h00, rbyte_q};  fin = 1'b1;
            end
            PH_ID: begin
              if (idx_q == 3'd0) begin
                rsp_d.rdata[15:8] = rbyte_q;  idx_d = 3'd1;
                rd_go = 1'b1;  go_addr = 19'h00001;
              end else begin
                rsp_d.rdata[7:0] = rbyte_q;  phase_d = PH_EXIT;  idx_d = 3'd0;
                wr_go = 1'b1;
                go_addr = {4'h0, sfc_pkg::SFC_CMD_ADDR_A};  go_data = sfc_pkg::SFC_CODE_UNLK1;
              end
            end
            default: begin
              // done when toggle is still and bit 7 is true data
              prev6_d = rbyte_q[6];  havep_d = 1'b1;
              if (havep_q && rbyte_q[6] == prev6_q && rbyte_q[7] == bit7_q) begin
                fin = 1'b1;
              end else if (wc_q >= WC_CYCLES[19:0]) begin
                rsp_d.err = 1'b1;  fin = 1'b1;
              end else begin
                rd_go = 1'b1;  go_addr = last_q;
              end
            end
          endcase
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (wr_go) begin
      state_d = ST_WSET;  cnt_d = 3'd0;  pins_d.addr = go_addr;  pins_d.dq_out = go_data;
      pins_d.dq_oe = 1'b1;  pins_d.ce_n = 1'b0;  pins_d.oe_n = 1'b1;  pins_d.we_n = 1'b1;
    end else if (rd_go) begin
      state_d = ST_RLOW;  cnt_d = 3'd0;  pins_d.addr = go_addr;  pins_d.dq_oe = 1'b0;
      pins_d.ce_n = 1'b0;  pins_d.oe_n = 1'b0;  pins_d.we_n = 1'b1;
    end else if (fin) begin
      state_d = ST_IDLE;  rsp_d.done = 1'b1;  pins_d.ce_n = 1'b1;
      pins_d.oe_n = 1'b1;  pins_d.we_n = 1'b1;  pins_d.dq_oe = 1'b0;
    end
  end

  // Registers; the chip is deselected and the bus released out of reset.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;  phase_q <= PH_CMD;  op_q <= sfc_pkg::SFC_OP_READ;
      pins_q <= '{addr: 19'h00000, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                  dq_out: 8'h00, dq_oe: 1'b0};
      rsp_q <= '0;  cnt_q <= 3'd0;  idx_q <= 3'd0;  byte_q <= 9'd0;
      addr_q <= 19'h00000;  last_q <= 19'h00000;  bit7_q <= 1'b0;  prev6_q <= 1'b0;
      havep_q <= 1'b0;  rbyte_q <= 8'h00;  blc_q <= 12'd0;  wc_q <= 20'd0;
    end else begin
      state_q <= state_d;  phase_q <= phase_d;  op_q <= op_d;  pins_q <= pins_d;
      rsp_q <= rsp_d;  cnt_q <= cnt_d;  idx_q <= idx_d;  byte_q <= byte_d;
      addr_q <= addr_d;  last_q <= last_d;  bit7_q <= bit7_d;  prev6_q <= prev6_d;
      havep_q <= havep_d;  rbyte_q <= rbyte_d;  blc_q <= blc_d;  wc_q <= wc_d;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_write_oe_high: assert property (@(posedge clk) disable iff (!reset_n)
    (!pins.we_n && !pins.ce_n) |-> pins.oe_n) else $error("oe low during write");
  chk_sector_addr: assert property (@(posedge clk) disable iff (!reset_n)
    ($fell(pins.we_n) && phase_q == PH_LOAD) |-> pins.addr[18:8] == addr_q[18:8])
    else $error("sector address wrong during load");
  chk_full_page: assert property (@(posedge clk) disable iff (!reset_n)
    ($rose(phase_q == PH_POLL) && op_q == sfc_pkg::SFC_OP_PROG && !rsp_q.err)
    |-> byte_q == 9'(sfc_pkg::SFC_PAGE_BYTES)) else $error("poll began before full page");
  chk_load_spacing: assert property (@(posedge clk) disable iff (!reset_n)
    (phase_q == PH_LOAD) |-> blc_q <= 12'(sfc_pkg::SFC_BLC_CYC))
    else $error("byte load gap too long");
  chk_poll_addr: assert property (@(posedge clk) disable iff (!reset_n)
    ($fell(pins.oe_n) && phase_q == PH_POLL) |-> pins.addr == last_q)
    else $error("poll address moved");
  chk_id_addr: assert property (@(posedge clk) disable iff (!reset_n)
    ($fell(pins.oe_n) && phase_q == PH_ID) |-> pins.addr[18:1] == 18'h00000)
    else $error("id read address not low");
  chk_write_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(pins.we_n) |-> (!pins.we_n)[*5] ##1 pins.we_n[*5])
    else $error("write strobe timing wrong");

endmodule

// >>> dv/sfc_flash_model.sv
// Pin-level model of the sector flash, with a monitor that counts host misbehaviour.
// Assumes pins change only after clk edges; reset_n stands in for power-up.
`timescale 1ns/100ps
module sfc_flash_model #(
  parameter logic [7:0]  MAKER_CODE = 8'h3c,  // Arbitrary value.
  parameter logic [7:0]  PART_CODE  = 8'h5a,  // Arbitrary value.
  parameter logic [18:0] BOOT_BYTES = 19'h04000,
  parameter int          BUSY_FAST  = 60,
  parameter int          BUSY_SLOW  = 400
) (
  // Clock, power-up and pins
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire sfc_pkg::sfc_pins_type pins,
  input  wire logic                  slow,
  // Data back and violation count
  output logic [7:0]                 dq_in,
  output int                         viol_cnt
);
  // ********************
  // Array and commands
  // ********************
  logic [7:0]  mem [logic [18:0]];
  logic [7:0]  last, hold, rd;
  logic [18:0] poll_a;
  logic [10:0] sect;
  logic [1:0]  seq;
  logic        we_q, rd_q, rd_on, id_md, arm, lk_wait, lk_lo, lk_hi, load, tog, polled;
  int          busy, nload, gap;

  // Lockout is meant to outlive power cycles, so reset_n never clears it.
  initial {lk_lo, lk_hi} = 2'b00;

  // Read path. A released bus shows the inverse of the last value, not a stale copy.
  // status and codes.
  always @* begin
    rd_on = !pins.ce_n && !pins.oe_n && pins.we_n;
    if (busy > 0) rd = {~last[7], tog, 6'h15};
    else if (id_md && pins.addr[18:1] == 18'h0) rd = pins.addr[0] ? PART_CODE : MAKER_CODE;
    else rd = mem.exists(pins.addr) ? mem[pins.addr] : 8'hxx;
    dq_in = rd_on ? rd : ~hold;
  end

  // Write decode, program timer and host monitor.
  always @(posedge clk) begin
    if (!reset_n) begin
      {seq, id_md, arm, lk_wait, load, polled, tog} = '0;
      {busy, gap, viol_cnt} = '0;
      {we_q, rd_q, hold} = {2'b10, 8'h00};
    end else begin
      if (rd_on) hold = rd;
      if (!pins.we_n && !pins.ce_n && !pins.oe_n) viol_cnt++;
      if (busy > 0) busy--;
      if (busy > 0 && rd_on && !rd_q) begin
        tog = ~tog;
        if (polled && poll_a != pins.addr) viol_cnt++;
        polled = 1'b1;
        poll_a = pins.addr;
      end
      gap = load ? gap + 1 : 0;
      if (gap > sfc_pkg::SFC_BLC_CYC) viol_cnt++;
      if (we_q && !pins.we_n && !pins.ce_n && busy == 0) begin
        gap = 0;
        if (load) begin
          if (nload == 0) sect = pins.addr[18:8];
          if (pins.addr[18:8] != sect) viol_cnt++;
          if (!(lk_lo && pins.addr < BOOT_BYTES) && !(lk_hi && pins.addr > ~BOOT_BYTES))
            mem[pins.addr] = pins.dq_out;
          last = pins.dq_out;
          nload++;
          // program after full page, then protected again.
          if (nload == 256) begin
            load = 1'b0;
            busy = slow ? BUSY_SLOW : BUSY_FAST;
            polled = 1'b0;
          end
        end else if (lk_wait) begin
          lk_wait = 1'b0;
          lk_lo |= pins.dq_out == 8'hff && pins.addr == 19'h00000;
          lk_hi |= pins.dq_out == 8'hff && pins.addr == 19'h7ffff;
          {busy, last, polled} = {BUSY_FAST, 8'hff, 1'b0};
        end else if (seq == 0 && pins.addr[14:0] == 15'h5555 && pins.dq_out == 8'haa) seq = 1;
        else if (seq == 1 && pins.addr[14:0] == 15'h2aaa && pins.dq_out == 8'h55) seq = 2;
        else if (seq == 2 && pins.addr[14:0] == 15'h5555) begin
          seq = 0;
          case (pins.dq_out)
            8'ha0: {load, nload} = {1'b1, 32'd0};
            8'h90: id_md = 1'b1;
            8'hf0: id_md = 1'b0;
            8'h80: arm = 1'b1;
            8'h40: {lk_wait, arm} = {arm, 1'b0};
            default: arm = 1'b0;
          endcase
        end else seq = 0;
      end
      we_q = pins.we_n;
      rd_q = rd_on;
    end
  end
endmodule

// >>> dv/test_sfc_host.sv
// Self-checking bench for the sector flash host controller against the flash model.
// Assumes the package and the model are compiled first.
`timescale 1ns/100ps
module test_sfc_host;
  // ********************
  // Bench
  // ********************
  localparam logic [7:0] MAKER = 8'h3c;  // Arbitrary value.
  localparam logic [7:0] PART  = 8'h5a;  // Arbitrary value.
  localparam int         POLL_LIMIT    = 200;  // Poll limit, kept short for simulation.
  localparam int         BUSY_FAST_CYC = 60;   // Model program time, normal.
  localparam int         BUSY_SLOW_CYC = 400;  // Model program time, overrunning the limit.
  logic                  clk, reset_n, req_valid, req_ready, wr_valid, wr_ready, slow, tk;
  logic [7:0]            wr_data, dq_in;
  logic [10:0]           s;
  sfc_pkg::sfc_req_type  req;
  sfc_pkg::sfc_rsp_type  rsp;
  sfc_pkg::sfc_pins_type pins;
  int                    n_errors, samples_checked, viol_cnt;
  logic [7:0]            fq [$];
  logic [7:0]            page [256];
  logic [7:0]            old0 [256];

  sfc_host #(.WC_CYCLES(POLL_LIMIT)) uut (.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .rsp(rsp), .pins(pins), .dq_in(dq_in));
  sfc_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .BUSY_FAST(BUSY_FAST_CYC),
    .BUSY_SLOW(BUSY_SLOW_CYC)) flash (.clk(clk),
    .reset_n(reset_n), .pins(pins), .slow(slow), .dq_in(dq_in), .viol_cnt(viol_cnt));

  // Clock at 25 MHz.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // A program is expected to time out only when the model stays busy past the poll limit.
  function automatic logic exp_err(input logic slow_mode);
    return (slow_mode ? BUSY_SLOW_CYC : BUSY_FAST_CYC) > POLL_LIMIT;
  endfunction

  task automatic final_report();
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One request, held until taken, then a bounded wait for its done pulse.
  task automatic do_req(input sfc_pkg::sfc_op_type op, input logic [18:0] a);
    int i;
    #1;
    req = '{op: op, addr: a};
    req_valid = 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (req_ready !== 1'b1 && i < 50);
    #1;
    req_valid = 1'b0;
    for (i = 0; i < 40000 && rsp.done !== 1'b1; i++) @(posedge clk);
    if (i == 40000) begin
      n_errors++;
      final_report();
    end
  endtask

  // Random page onto the stream. In sector zero bytes 0 and 255 keep bit 7 set: the
  // lockout poll reads byte 0, and the refused program after lockout polls byte 255,
  // which then still holds old data whose bit 7 must match the new last byte.
  task automatic prog(input logic [10:0] sec, input logic err, input logic full);
    for (int k = 0; k < 256; k++) page[k] = 8'($urandom);
    if (sec == 0) {page[0][7], page[255][7]} = 2'b11;
    for (int k = 0; k < 256; k++) fq.push_back(page[k]);
    if (full) begin
      repeat (40) @(posedge clk);
      check(wr_ready, 1'b0);
      check(fq.size(), 248);
    end
    do_req(sfc_pkg::SFC_OP_PROG, {sec, 8'h00});
    check(rsp.err, err);
  endtask

  task automatic verify(input logic [10:0] sec, input logic [7:0] d [256]);
    for (int k = 0; k < 256; k++) begin
      do_req(sfc_pkg::SFC_OP_READ, {sec, 8'(k)});
      check(rsp.rdata, {8'h00, d[k]});
    end
  endtask

  // Byte stream with random stalls; an offered byte stays until taken.
  always @(posedge clk) begin
    tk = wr_valid && wr_ready;
    if (tk) void'(fq.pop_front());
    #1;
    if (tk || !wr_valid) begin
      wr_valid = fq.size() != 0 && $urandom_range(3) != 0;
      wr_data = wr_valid ? fq[0] : 8'h00;
    end
  end

  // Main sequence.
  initial begin
    {req_valid, wr_valid, slow, reset_n} = '0;
    {req, wr_data, n_errors, samples_checked} = '0;
    void'($urandom(32'hecaf));
    repeat (10) @(posedge clk);
    #1;
    reset_n = 1'b1;
    check({pins.ce_n, pins.oe_n, pins.we_n, pins.dq_oe}, 4'he);
    @(posedge clk);
    prog(11'h000, 1'b0, 1'b1);
    verify(11'h000, page);
    old0 = page;
    do_req(sfc_pkg::SFC_OP_ID, 19'h00000);
    check(rsp.rdata, {MAKER, PART});
    do_req(sfc_pkg::SFC_OP_READ, 19'h00001);
    check(rsp.rdata, {8'h00, old0[1]});
    s = 11'($urandom_range(16, 2031));
    repeat (2) begin
      prog(s, 1'b0, 1'b0);
      verify(s, page);
    end
    slow <= 1'b1;
    prog(s, exp_err(1'b1), 1'b0);
    slow <= 1'b0;
    repeat (300) @(posedge clk);
    do_req(sfc_pkg::SFC_OP_LOCK, 19'h00000);
    check(rsp.err, exp_err(1'b0));
    prog(11'h000, 1'b0, 1'b0);
    verify(11'h000, old0);
    check(viol_cnt, 0);
    final_report();
  end
endmodule
